// ---- rtl/tuner_pll_pkg.sv ----
// Package for the tuner synthesizer control and readout block.
// Assumes a 20 MHz system clock; all times are turned into cycles here.
package tuner_pll_pkg;

    // Clock rate
    localparam int CLK_HZ       = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;

    // Serial frame addresses, values arbitrary
    localparam logic [7:0] ADDR_IN  = 8'h28;
    localparam logic [7:0] ADDR_OUT = 8'h29;

    // Control word field positions, bit 0 shifted in first
    localparam int DIV_LSB  = 0;
    localparam int DIV_W    = 16;
    localparam int SNS_BIT  = 16;
    localparam int DVS_BIT  = 17;
    localparam int CTE_BIT  = 18;
    localparam int GT0_BIT  = 19;
    localparam int GT1_BIT  = 20;
    localparam int IFS_BIT  = 21;
    localparam int DLC_BIT  = 22;
    localparam int TEST_LSB = 23;
    localparam int TEST_W   = 3;
    localparam int CTRL_W   = 32;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Readout frame: two port bits, lock flag, twenty count bits
    localparam int COUNT_W = 20;
    localparam int OUT_W   = 23;

    // Register offsets on the AHB-Lite slave
    localparam logic [11:0] REG_REF_PERIOD = 12'h000;
    localparam logic [11:0] REG_STATUS     = 12'h004;
    localparam logic [11:0] REG_CONTROL    = 12'h008;
    localparam logic [15:0] REF_PERIOD_RESET = 16'h00C8;
    localparam int ST_LOCK  = 20;
    localparam int ST_PORT1 = 21;
    localparam int ST_PORT2 = 22;
    localparam int ST_DONE  = 23;

    // Unlock detection window in ns, longest time so rounded down
    localparam int UL_WINDOW_NS  = 1110;
    localparam int UL_WINDOW_CYC = UL_WINDOW_NS / CLK_PERIOD_NS;

    // IF counter wait and gate times in microseconds
    localparam int WAIT_SHORT_US = 4000;
    localparam int WAIT_LONG_US  = 8000;
    localparam int GATE0_US      = 4000;
    localparam int GATE1_US      = 8000;
    localparam int GATE2_US      = 32000;
    localparam int GATE3_US      = 64000;
    localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
    localparam int WAIT_SHORT_CYC = WAIT_SHORT_US * CYC_PER_US;
    localparam int WAIT_LONG_CYC  = WAIT_LONG_US * CYC_PER_US;
    localparam int GATE0_CYC      = GATE0_US * CYC_PER_US;
    localparam int GATE1_CYC      = GATE1_US * CYC_PER_US;
    localparam int GATE2_CYC      = GATE2_US * CYC_PER_US;
    localparam int GATE3_CYC      = GATE3_US * CYC_PER_US;
    localparam int TMR_W          = 21;

    // Serial transfer mode and IF counter phase
    typedef enum logic [1:0] {XFER_NONE, XFER_IN, XFER_OUT} xfer_t;
    typedef enum logic [1:0] {IFC_IDLE, IFC_WAIT, IFC_GATE, IFC_DONE} ifc_t;

endpackage : tuner_pll_pkg

// ---- rtl/tuner_pll_serial_readout.sv ----
// Control and readout logic of a tuner frequency synthesizer.
// Assumes serial pins, local and IF inputs arrive asynchronously and are
// slow enough to be edge-detected at 20 MHz; AHB-Lite master on clk.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1 - Pump force bit drives charge pump low
// RULE2 - Controller writes sensitivity select as 1
// RULE3 - Sensitivity bit 0 selects degraded IF input
// RULE4 - Controller writes all test bits zero
// RULE5 - Reset clears the three test bits
// RULE6 - Readout port bits are sampled pin levels
// RULE7 - Lock flag: 0 unlocked, 1 locked
// RULE8 - Twenty-bit IF count, shifted out MSB first
// RULE9 - Each transfer opens with eight-bit mode address
// RULE10 - FM input prescaled by two, then divided
// RULE11 - AM swallow mode divides by full setting
// RULE12 - Direct AM mode uses bits above four
// RULE13 - Controller clears run bit before starting count
// RULE14 - Count starts on run rising, cleared when 0
// RULE15 - Control data applied at chip enable fall
// RULE16 - Controller reads count before clearing run bit
// RULE17 - Gate select picks 4, 8, 32, 64 ms
// RULE18 - Wait 4 or 8 ms before gate opens
// RULE19 - Count equals IF pulses inside gate window
// RULE20 - Lock judged once per reference period
// RULE21 - Controller waits two reference periods after change
// RULE22 - Controller confirms station detect before counting
// RULE23 - Unlock sticks until next serial transfer
// RULE24 - Controller holds chip enable high during transfer
// RULE25 - Readout order: ports, lock flag, count bits
module tuner_pll_serial_readout
    import tuner_pll_pkg::*;
#(
    parameter int WAIT_SHORT = WAIT_SHORT_CYC,
    parameter int WAIT_LONG  = WAIT_LONG_CYC,
    parameter int GATE0      = GATE0_CYC,
    parameter int GATE1      = GATE1_CYC,
    parameter int GATE2      = GATE2_CYC,
    parameter int GATE3      = GATE3_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Three-wire serial link
    input  wire logic        chip_enable,
    input  wire logic        serial_clock_line,
    input  wire logic        serial_in_pin,
    output logic             serial_out,
    output logic             serial_out_oe,
    // Port pins and signal inputs
    input  wire logic        bidir_port_one,
    input  wire logic        bidir_port_two,
    input  wire logic        fm_local_input,
    input  wire logic        am_local_input,
    input  wire logic        if_signal_input,
    // Charge pump output and analogue controls
    output logic             pump_out,
    output logic             pump_oe,
    output logic             if_reduced_sense,
    output logic [2:0]       factory_test_bits,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);

    typedef struct packed {
        logic [2:0]          ce_s;   // bit0 first stage, bit1 second, bit2 previous
        logic [2:0]          cl_s;
        logic [1:0]          di_s;
        logic [2:0]          if_s;
        logic [2:0]          fm_s;
        logic [2:0]          am_s;
        logic [1:0]          p1_s;
        logic [1:0]          p2_s;
        xfer_t               mode;
        logic [7:0]          addr_sh;
        logic [CTRL_W-1:0]   in_sh;
        logic [OUT_W-1:0]    out_sh;
        logic [CTRL_W-1:0]   ctrl;
        logic                run_d;
        logic                pre;
        logic [15:0]         div_cnt;
        logic [15:0]         ref_cnt;
        logic                fr_q;
        logic                fp_q;
        logic [15:0]         err_cnt;
        logic                lock_flag;
        ifc_t                ifc;
        logic [TMR_W-1:0]    tmr;
        logic [COUNT_W-1:0]  if_cnt;
        logic                sout_oe;
        logic                pump_out;
        logic                pump_oe;
        logic                ahb_wr;
        logic [11:0]         ahb_addr;
        logic [15:0]         ref_period;
        logic                hreadyout;
        logic [31:0]         hrdata;
    } state_t;

    state_t s;
    state_t next_s;

    // Gate length in cycles for a gate select code
    function automatic logic [TMR_W-1:0] gate_len(input logic [1:0] gt);
        unique case (gt)
            2'h0: gate_len = TMR_W'(GATE0);
            2'h1: gate_len = TMR_W'(GATE1);
            2'h2: gate_len = TMR_W'(GATE2);
            2'h3: gate_len = TMR_W'(GATE3);
        endcase
    endfunction : gate_len

    // Wait before the gate: short gates take the short wait
    function automatic logic [TMR_W-1:0] wait_len(input logic [1:0] gt);
        wait_len = gt[1] ? TMR_W'(WAIT_LONG) : TMR_W'(WAIT_SHORT);
    endfunction : wait_len

    // Combinational next state
    always_comb begin
        logic        ce_rise;
        logic        ce_fall;
        logic        cl_rise;
        logic        cl_fall;
        logic        if_edge;
        logic        loc_edge;
        logic        fr_pulse;
        logic        fp_pulse;
        logic        unlock_now;
        logic [15:0] divisor;
        logic [1:0]  gt;
        logic        counter_run;
        logic        ahb_go;
        next_s     = s;
        ce_rise    = s.ce_s[1] & ~s.ce_s[2];
        ce_fall    = ~s.ce_s[1] & s.ce_s[2];
        cl_rise    = s.cl_s[1] & ~s.cl_s[2];
        cl_fall    = ~s.cl_s[1] & s.cl_s[2];
        if_edge    = s.if_s[1] & ~s.if_s[2];
        gt         = {s.ctrl[GT1_BIT], s.ctrl[GT0_BIT]};
        counter_run        = s.ctrl[CTE_BIT];
        fr_pulse   = 1'b0;
        fp_pulse   = 1'b0;
        unlock_now = 1'b0;
        ahb_go     = hsel & htrans[1] & hready;
        loc_edge   = 1'b0;
        divisor    = s.ctrl[DIV_LSB +: DIV_W];                    // RULE10 RULE11

        // Two-stage synchronisers; on the edge-detected inputs stage two feeds an edge history flop
        next_s.ce_s = {s.ce_s[1], s.ce_s[0], chip_enable};
        next_s.cl_s = {s.cl_s[1], s.cl_s[0], serial_clock_line};
        next_s.di_s = {s.di_s[0], serial_in_pin};
        next_s.if_s = {s.if_s[1], s.if_s[0], if_signal_input};
        next_s.fm_s = {s.fm_s[1], s.fm_s[0], fm_local_input};
        next_s.am_s = {s.am_s[1], s.am_s[0], am_local_input};
        next_s.p1_s = {s.p1_s[0], bidir_port_one};
        next_s.p2_s = {s.p2_s[0], bidir_port_two};

        // Local oscillator edge: FM passes a divide-by-two first
        if (s.ctrl[DVS_BIT]) begin
            if (s.fm_s[1] & ~s.fm_s[2]) begin
                next_s.pre = ~s.pre;
                loc_edge   = s.pre;                               // RULE10
            end
        end else begin
            loc_edge = s.am_s[1] & ~s.am_s[2];                    // RULE11
        end

        // Divisor: direct mode drops the four low bits
        if (!(s.ctrl[DVS_BIT] | s.ctrl[SNS_BIT])) begin
            divisor = {4'h0, s.ctrl[DIV_LSB+4 +: DIV_W-4]};        // RULE12
        end

        // Programmable divider
        if (loc_edge) begin
            if (s.div_cnt + 16'h1 >= divisor) begin
                next_s.div_cnt = 16'h0;
                fp_pulse       = 1'b1;
            end else begin
                next_s.div_cnt = s.div_cnt + 16'h1;
            end
        end

        // Reference divider from the system clock
        if (s.ref_cnt + 16'h1 >= s.ref_period) begin
            next_s.ref_cnt = 16'h0;
            fr_pulse       = 1'b1;
        end else begin
            next_s.ref_cnt = s.ref_cnt + 16'h1;
        end

        // Phase detector: the second edge clears both flags, so they are never set together
        next_s.fr_q = (s.fr_q | fr_pulse) & ~(s.fp_q | fp_pulse);
        next_s.fp_q = (s.fp_q | fp_pulse) & ~(s.fr_q | fr_pulse);
        if (s.ctrl[DLC_BIT]) begin
            next_s.pump_out = 1'b0;                               // RULE1
            next_s.pump_oe  = 1'b1;                               // RULE1
        end else begin
            next_s.pump_out = s.fp_q;
            next_s.pump_oe  = s.fp_q | s.fr_q;
        end

        // Phase error accumulated over one reference period, judged at its end
        if (fr_pulse) begin
            unlock_now     = s.err_cnt > 16'(UL_WINDOW_CYC);      // RULE20
            next_s.err_cnt = 16'h0;
        end else if ((s.fr_q | s.fp_q) && s.err_cnt != 16'hFFFF) begin
            next_s.err_cnt = s.err_cnt + 16'h1;
        end

        // Serial link: address while chip enable is low, data while high
        if (cl_rise && !s.ce_s[1]) begin
            next_s.addr_sh = {s.di_s[1], s.addr_sh[7:1]};
        end
        if (ce_rise) begin
            next_s.mode = XFER_NONE;
            if (s.addr_sh == ADDR_IN) begin
                next_s.mode  = XFER_IN;                           // RULE9
                next_s.in_sh = '0;
            end else if (s.addr_sh == ADDR_OUT) begin
                next_s.mode   = XFER_OUT;                         // RULE9
                next_s.out_sh = {s.p2_s[1], s.p1_s[1], s.lock_flag, s.if_cnt}; // RULE25 RULE6 RULE8
            end
        end else if (ce_fall) begin
            if (s.mode == XFER_IN) begin
                next_s.ctrl = s.in_sh;                            // RULE15
            end
            next_s.mode = XFER_NONE;
        end else if (s.mode == XFER_IN && cl_rise) begin
            next_s.in_sh = {s.di_s[1], s.in_sh[CTRL_W-1:1]};
        end else if (s.mode == XFER_OUT && cl_fall) begin
            next_s.out_sh = {s.out_sh[OUT_W-2:0], 1'b0};          // RULE8
        end
        // Open drain: drive low only while a zero is being shown
        next_s.sout_oe = (next_s.mode == XFER_OUT) & ~next_s.out_sh[OUT_W-1];

        // Lock flag sticks at unlocked until a transfer; a new unlock wins
        if (unlock_now) begin
            next_s.lock_flag = 1'b0;                              // RULE7 RULE23
        end else if (ce_rise && (s.addr_sh == ADDR_IN || s.addr_sh == ADDR_OUT)) begin
            next_s.lock_flag = 1'b1;                              // RULE23
        end

        // IF counter sequence
        next_s.run_d = counter_run;
        if (!counter_run) begin
            next_s.ifc    = IFC_IDLE;                             // RULE14
            next_s.if_cnt = '0;                                   // RULE14
        end else begin
            unique case (s.ifc)
                IFC_IDLE: begin
                    if (!s.run_d) begin
                        next_s.ifc = IFC_WAIT;                    // RULE14
                        next_s.tmr = wait_len(gt);                // RULE18
                    end
                end
                IFC_WAIT: begin
                    next_s.tmr = s.tmr - TMR_W'(1);
                    if (s.tmr == TMR_W'(1)) begin
                        next_s.ifc = IFC_GATE;
                        next_s.tmr = gate_len(gt);                // RULE17
                    end
                end
                IFC_GATE: begin
                    if (if_edge) begin
                        next_s.if_cnt = s.if_cnt + COUNT_W'(1);   // RULE19
                    end
                    next_s.tmr = s.tmr - TMR_W'(1);
                    if (s.tmr == TMR_W'(1)) begin
                        next_s.ifc = IFC_DONE;                    // RULE19
                    end
                end
                IFC_DONE: next_s.ifc = IFC_DONE;                  // held until run bit clears
            endcase
        end

        // AHB-Lite: zero wait states, read data prepared in address phase
        next_s.hreadyout = 1'b1;
        next_s.ahb_wr    = ahb_go & hwrite;
        next_s.ahb_addr  = haddr[11:0];
        if (s.ahb_wr && s.ahb_addr == REG_REF_PERIOD) begin
            next_s.ref_period = (hwdata[15:0] == 16'h0) ? 16'h1 : hwdata[15:0];
        end
        next_s.hrdata = 32'h0000_0000;
        if (ahb_go && !hwrite) begin
            unique case (haddr[11:0])
                REG_REF_PERIOD: next_s.hrdata = {16'h0000, s.ref_period};
                REG_STATUS: begin
                    next_s.hrdata[COUNT_W-1:0] = s.if_cnt;
                    next_s.hrdata[ST_LOCK]     = s.lock_flag;
                    next_s.hrdata[ST_PORT1]    = s.p1_s[1];
                    next_s.hrdata[ST_PORT2]    = s.p2_s[1];
                    next_s.hrdata[ST_DONE]     = (s.ifc == IFC_DONE);
                end
                REG_CONTROL:    next_s.hrdata = s.ctrl;
                default:        next_s.hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Single register stage; reset gives every field a constant
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s            <= '0;
            s.mode       <= XFER_NONE;
            s.ifc        <= IFC_IDLE;
            s.ctrl       <= CTRL_RESET;                           // RULE5
            s.lock_flag  <= 1'b1;
            s.hreadyout  <= 1'b1;                                 // Bus never stalls, even in reset
            s.ref_period <= REF_PERIOD_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs from flops; serial_out and hresp are tied to zero
    assign serial_out        = 1'b0;
    assign serial_out_oe     = s.sout_oe;
    assign pump_out          = s.pump_out;
    assign pump_oe           = s.pump_oe;
    assign if_reduced_sense  = ~s.ctrl[IFS_BIT];                  // RULE3
    assign factory_test_bits = s.ctrl[TEST_LSB +: TEST_W];        // RULE5
    assign hreadyout         = s.hreadyout;
    assign hresp             = 1'b0;
    assign hrdata            = s.hrdata;

endmodule : tuner_pll_serial_readout

`default_nettype wire

// ---- tb/tuner_pll_serial_readout_properties.sv ----
// Concurrent checks on the ports of the synthesizer control and readout block.
// Assumes one 20 MHz clock domain and the package field map.
`timescale 1ns/1ps
`default_nettype none
module tuner_pll_serial_readout_checker
    import tuner_pll_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        chip_enable,
    input wire logic        serial_out_oe,
    input wire logic        pump_out,
    input wire logic        pump_oe,
    input wire logic        if_reduced_sense,
    input wire logic [2:0]  factory_test_bits,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata
);
    typedef struct packed {
        logic ctrl_rd;
    } chk_state_t;
    chk_state_t st;
    chk_state_t next_st;
    // Marks the data phase of a control word read, so hrdata can be trusted
    always_comb begin
        next_st = st;
        next_st.ctrl_rd = hsel && htrans[1] && hready && !hwrite
                          && (haddr[11:0] == REG_CONTROL);
        if (!rst_n)
            next_st = '0;
    end
    always_ff @(posedge clk) begin
        st <= next_st;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Synchroniser latency is a few cycles, so only long levels count
    sequence s_ce_high;
        chip_enable [*6];
    endsequence
    sequence s_ce_low;
        !chip_enable [*8];
    endsequence
    property p_ready; hreadyout == 1'b1; endproperty
    a_ready: assert property (p_ready) else $error("slave not ready");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("slave answered error");
    property p_test_reset; $rose(rst_n) |-> factory_test_bits == 3'h0; endproperty
    a_test_reset: assert property (p_test_reset)
        else $error("test bits not cleared by reset");
    property p_pump_force; st.ctrl_rd && hrdata[DLC_BIT] |-> pump_oe && !pump_out; endproperty
    a_pump_force: assert property (p_pump_force)
        else $error("pump not forced low");
    property p_sense; st.ctrl_rd |-> if_reduced_sense == !hrdata[IFS_BIT]; endproperty
    a_sense: assert property (p_sense)
        else $error("sensitivity mode wrong");
    property p_test_applied;
        st.ctrl_rd |-> factory_test_bits == hrdata[TEST_LSB +: TEST_W];
    endproperty
    a_test_applied: assert property (p_test_applied)
        else $error("test bits differ from control word");
    property p_ce_hold;
        s_ce_high |-> $stable(if_reduced_sense) && $stable(factory_test_bits);
    endproperty
    a_ce_hold: assert property (p_ce_hold)
        else $error("control changed while chip enable high");
    property p_do_release; $fell(chip_enable) |-> ##[1:8] !serial_out_oe; endproperty
    a_do_release: assert property (p_do_release)
        else $error("data out not released");
    property p_do_idle; s_ce_low |-> !serial_out_oe; endproperty
    a_do_idle: assert property (p_do_idle)
        else $error("data out driven outside a frame");
endmodule : tuner_pll_serial_readout_checker
bind tuner_pll_serial_readout tuner_pll_serial_readout_checker i_chk (
    .clk, .rst_n, .chip_enable, .serial_out_oe, .pump_out, .pump_oe, .if_reduced_sense,
    .factory_test_bits, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .hrdata);
`default_nettype wire

// ---- tb/serial_master_model.sv ----
// Behavioural three-wire master standing in for the system controller.
// Assumes the block finds link edges with its own clock; DO has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module serial_master_model
    import tuner_pll_pkg::*;
(
    input  wire logic clk,
    output logic      chip_enable,
    output logic      serial_clock_line,
    output logic      serial_in_pin,
    input  wire logic serial_out_oe
);
    localparam int HALF_NS = 200;
    initial begin
        chip_enable       = 1'b0;
        serial_clock_line = 1'b0;
        serial_in_pin     = 1'b0;
    end
    // Clock idles low between frames; data flips so no stale bit lingers
    task automatic shift_bits(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            serial_in_pin = v[i];
            #HALF_NS serial_clock_line = 1'b1;
            #HALF_NS serial_clock_line = 1'b0;
        end
        serial_in_pin = ~serial_in_pin;
    endtask : shift_bits
    // Input transfer: address, then the whole word under chip enable
    task automatic send_word(input logic [31:0] w);
        @(negedge clk);                           // Pins never move at the sampling edge
        shift_bits({24'h0, ADDR_IN}, 8);
        #HALF_NS chip_enable = 1'b1;
        shift_bits(w, CTRL_W);
        #HALF_NS chip_enable = 1'b0;
        #(2 * HALF_NS);
    endtask : send_word
    // Output transfer: sample late in each high phase, just before the fall
    task automatic read_frame(output logic [OUT_W-1:0] f);
        @(negedge clk);
        shift_bits({24'h0, ADDR_OUT}, 8);
        #HALF_NS chip_enable = 1'b1;
        #(2 * HALF_NS);
        for (int i = OUT_W - 1; i >= 0; i--) begin
            #HALF_NS serial_clock_line = 1'b1;
            #(HALF_NS - 10) f[i] = ~serial_out_oe;
            #10 serial_clock_line = 1'b0;
        end
        #HALF_NS chip_enable = 1'b0;
        #(2 * HALF_NS);
    endtask : read_frame
endmodule : serial_master_model
`default_nettype wire

// ---- tb/tuner_pll_serial_readout_tb_top.sv ----
// Self-checking bench for the synthesizer control and readout block.
// Assumes the serial master model and the checker bind are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin fails++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, s); end end
module tuner_pll_serial_readout_tb_top
    import tuner_pll_pkg::*;
;
    localparam int GATE_CYC [4] = '{10, 20, 40, 80};
    localparam int WAIT_S = 20;
    localparam int WAIT_L = 40;
    localparam int IF_PER = 10;
    localparam int LIMIT  = 60000;
    localparam logic [31:0] ROW_W [4] = '{32'h0022_07DE, 32'h0021_FFFF,
                                          32'h0000_0910, 32'h0060_0040};
    localparam logic ROW_RS [4]   = '{1'b0, 1'b0, 1'b1, 1'b0};
    localparam logic ROW_PUMP [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic             clk;
    logic             rst_n = 1'b0;
    logic             hsel = 1'b0;
    logic             hwrite = 1'b0;
    logic [1:0]       htrans = 2'b00;
    logic [2:0]       hsize = 3'h2;
    logic [31:0]      haddr = 32'h0;
    logic [31:0]      hwdata = 32'h0;
    logic             port1 = 1'b0;
    logic             port2 = 1'b0;
    logic             fm_in = 1'b0;
    logic             am_in = 1'b0;
    logic             if_in = 1'b0;
    logic             hreadyout, hresp, ce, sclk, sdin, do_oe, pump_out, pump_oe, reduced;
    logic [2:0]       test_bits;
    logic [31:0]      hrdata, rd;
    logic [OUT_W-1:0] frame;
    int               fails = 0;
    int               checks = 0;
    int               cyc = 0;
    int               t0, dt, exp_cnt;

    tuner_pll_serial_readout #(.WAIT_SHORT(WAIT_S), .WAIT_LONG(WAIT_L),
        .GATE0(GATE_CYC[0]), .GATE1(GATE_CYC[1]), .GATE2(GATE_CYC[2]), .GATE3(GATE_CYC[3])
    ) i_tuner_pll_serial_readout (.clk(clk), .rst_n(rst_n), .chip_enable(ce),
        .serial_clock_line(sclk), .serial_in_pin(sdin), .serial_out(), .serial_out_oe(do_oe),
        .bidir_port_one(port1), .bidir_port_two(port2), .fm_local_input(fm_in),
        .am_local_input(am_in), .if_signal_input(if_in), .pump_out(pump_out),
        .pump_oe(pump_oe), .if_reduced_sense(reduced), .factory_test_bits(test_bits),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata));
    serial_master_model i_serial_master_model (.chip_enable(ce), .serial_clock_line(sclk),
        .serial_in_pin(sdin), .serial_out_oe(do_oe), .clk(clk));

    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end
    // Free-running inputs; the IF period divides every gate so counts are exact
    always @(posedge clk) begin
        cyc   <= cyc + 1;
        if_in <= (cyc % IF_PER) < (IF_PER / 2);
        fm_in <= cyc[2];
        am_in <= cyc[3];
        if (cyc == LIMIT) begin
            fails++;
            conclude();
        end
    end
    // One single word transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {20'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : ahb
    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Control words beside the analogue controls they must set
        for (int i = 0; i < 4; i++) begin
            i_serial_master_model.send_word(ROW_W[i]);
            ahb(1'b0, REG_CONTROL, 32'h0, rd);
            `CHK("control", ROW_W[i], rd)
            `CHK("reduced_sense", ROW_RS[i], reduced)
            `CHK("test_bits", 3'h0, test_bits)
            if (ROW_PUMP[i])
                `CHK("pump_low", 1'b1, pump_oe && !pump_out)
        end
        // Every gate code: clear, start, poll for done, read both ways, clear
        for (int g = 0; g < 4; g++) begin
            port1 <= g[0];
            port2 <= g[1];
            i_serial_master_model.send_word(32'h0020_0000 | (g << GT0_BIT));
            i_serial_master_model.send_word(32'h0024_0000 | (g << GT0_BIT));
            t0 = cyc;
            exp_cnt = GATE_CYC[g] / IF_PER;
            dt = (g < 2 ? WAIT_S : WAIT_L) + GATE_CYC[g];
            rd = 32'h0;
            while (rd[ST_DONE] !== 1'b1)
                ahb(1'b0, REG_STATUS, 32'h0, rd);
            `CHK("done_time", 1'b1, (cyc - t0 >= dt - 8) && (cyc - t0 <= dt + 24))
            `CHK("count_reg", exp_cnt[19:0], rd[19:0])
            i_serial_master_model.read_frame(frame);
            `CHK("frame_count", exp_cnt[19:0], frame[19:0])
            `CHK("frame_ports", g[1:0], frame[22:21])
            // Divisor 0 gives far too many feedback pulses per reference period
            `CHK("frame_lock", 1'b0, frame[20])
            i_serial_master_model.send_word(32'h0020_0000 | (g << GT0_BIT));
            ahb(1'b0, REG_STATUS, 32'h0, rd);
            `CHK("count_clear", 20'h0, rd[19:0])
        end
        // Test bits set on purpose, then a reset in mid-run must clear them
        i_serial_master_model.send_word(32'h03A0_0000);
        `CHK("test_set", 3'h7, test_bits)
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK("test_reset", 3'h0, test_bits)
        `CHK("reduced_reset", 1'b1, reduced)
        ahb(1'b0, REG_REF_PERIOD, 32'h0, rd);
        `CHK("ref_period", {16'h0, REF_PERIOD_RESET}, rd)
        ahb(1'b1, REG_REF_PERIOD, 32'h0000_0064, rd);
        ahb(1'b0, REG_REF_PERIOD, 32'h0, rd);
        `CHK("ref_write", 32'h0000_0064, rd)
        ahb(1'b0, 12'h00C, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        ahb(1'b1, REG_CONTROL, 32'hFFFF_FFFF, rd);
        ahb(1'b0, REG_CONTROL, 32'h0, rd);
        `CHK("control_ro", CTRL_RESET, rd)
        conclude();
    end
endmodule : tuner_pll_serial_readout_tb_top
`default_nettype wire
